// ==== rtl/spmb_pkg.sv ====
package spmb_pkg;
    // data width of every mailbox register
    localparam int DW = 8;
    // master-side register addresses
    localparam logic [1:0] MA_CMD = 2'h0;
    localparam logic [1:0] MA_AUX = 2'h1;
    localparam logic [1:0] MA_DAT2 = 2'h2;
    localparam logic [1:0] MA_STAT = 2'h3;
    // slave-side register addresses
    localparam logic [2:0] SA_STAT = 3'h3;
    localparam logic [2:0] SA_CTRL = 3'h4;
    // number of data registers per direction
    localparam int NDATA = 3;
    // status layout: master-written full flags low, slave-written full flags high
    localparam int ST_MW_LSB = 0;
    localparam int ST_SW_LSB = 4;
    // interrupt priority field
    localparam logic [1:0] PRIO_OFF = 2'h0;
    // mode pin codes seen by the slave
    localparam logic [1:0] SMODE_BOOT = 2'h1;
    localparam logic [1:0] SMODE_RUN = 2'h0;
    // slave reset hold time and its cycle count
    localparam int CLK_NS = 10;
    localparam int BOOT_HOLD_NS = 1000;
    localparam int BOOT_HOLD_CYC = (BOOT_HOLD_NS + CLK_NS - 1) / CLK_NS;
    // message buffer depth in the master end
    localparam int FIFO_DEPTH = 16;
    // master sequencer states, gray along the usual path
    typedef enum logic [3:0] {
        SPMB_BOOT = 4'h8,
        SPMB_IDLE = 4'h0,
        SPMB_P_RD = 4'h1,
        SPMB_P_WT = 4'h3,
        SPMB_SEND = 4'h2,
        SPMB_A_ST = 4'h6,
        SPMB_A_SW = 4'h7,
        SPMB_A_AX = 4'h5,
        SPMB_A_AW = 4'h4,
        SPMB_A_CM = 4'hC,
        SPMB_A_CW = 4'hD,
        SPMB_A_CL = 4'hF
    } spmb_state_t;
endpackage : spmb_pkg

// ==== rtl/spmb_if.sv ====
interface spmb_if;
    // master access strobes and data
    logic [1:0] m_addr;
    logic m_wr;
    logic m_rd;
    logic [spmb_pkg::DW-1:0] m_wdata;
    logic [spmb_pkg::DW-1:0] m_rdata;
    // attention line toward the master, active low
    logic master_attention_n;
    // slave reset and mode pins driven by the master
    logic slave_rst_n;
    logic [1:0] smode;

    modport dev (
        input m_addr, m_wr, m_rd, m_wdata, slave_rst_n, smode,
        output m_rdata, master_attention_n
    );
    modport mst (
        output m_addr, m_wr, m_rd, m_wdata, slave_rst_n, smode,
        input m_rdata, master_attention_n
    );
endinterface : spmb_if

// ==== rtl/spmb_dev.sv ====
module spmb_dev (
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // master side
    spmb_if.dev bus,
    // local processor access
    input wire logic [2:0] s_addr_i,
    input wire logic s_wr_i,
    input wire logic s_rd_i,
    input wire logic [spmb_pkg::DW-1:0] s_wdata_i,
    output logic [spmb_pkg::DW-1:0] s_rdata_o,
    // interrupt toward the local processor
    output logic irq_o,
    output logic [1:0] irq_level_o,
    // mode pins as seen after reset
    output logic [1:0] smode_o
);
    localparam int N = spmb_pkg::NDATA;

    logic [spmb_pkg::DW-1:0] mreg_r [N];
    logic [spmb_pkg::DW-1:0] sreg_r [N];
    logic [N-1:0] mfull_r;
    logic [N-1:0] sfull_r;
    logic [N-1:0] mw;
    logic [N-1:0] mr;
    logic [N-1:0] sw;
    logic [N-1:0] sr;
    logic [spmb_pkg::DW-1:0] status;
    logic [spmb_pkg::DW-1:0] m_rdata_r;
    logic [spmb_pkg::DW-1:0] s_rdata_r;
    logic attn_n_r;
    logic pend_r;
    logic [1:0] prio_r;
    logic [1:0] smode_r;
    logic srst;

    // register hit on a data address, shared by both sides
    function automatic logic hit(input logic [2:0] addr, input int idx);
        hit = (addr == 3'(idx));
    endfunction : hit

    // the master holds the slave in reset through its own pin
    assign srst = !bus.slave_rst_n;

    // per-register access strobes
    generate
        for (genvar j = 0; j < N; j++) begin : g_dec
            assign mw[j] = bus.m_wr && hit({1'b0, bus.m_addr}, j);
            assign mr[j] = bus.m_rd && hit({1'b0, bus.m_addr}, j);
            assign sw[j] = s_wr_i && hit(s_addr_i, j);
            assign sr[j] = s_rd_i && hit(s_addr_i, j);
        end
    endgenerate

    // data held by each register, written only by its owner side
    generate
        for (genvar j = 0; j < N; j++) begin : g_data
            always_ff @(posedge mclk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    mreg_r[j] <= 8'h00;
                    sreg_r[j] <= 8'h00;
                end else if (srst) begin
                    mreg_r[j] <= 8'h00;
                    sreg_r[j] <= 8'h00;
                end else begin
                    if (mw[j]) begin
                        mreg_r[j] <= bus.m_wdata;
                    end
                    if (sw[j]) begin
                        sreg_r[j] <= s_wdata_i;
                    end
                end
            end
        end
    endgenerate

    // full flags; a write landing with the read keeps the flag set
    generate
        for (genvar j = 0; j < N; j++) begin : g_full
            always_ff @(posedge mclk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    mfull_r[j] <= 1'b0;
                    sfull_r[j] <= 1'b0;
                end else if (srst) begin
                    mfull_r[j] <= 1'b0;
                    sfull_r[j] <= 1'b0;
                end else begin
                    if (mw[j]) begin
                        mfull_r[j] <= 1'b1;
                    end else if (sr[j]) begin
                        mfull_r[j] <= 1'b0;
                    end
                    if (sw[j]) begin
                        sfull_r[j] <= 1'b1;
                    end else if (mr[j]) begin
                        sfull_r[j] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // status image, unused bits read zero
    always_comb begin
        status = 8'h00;
        status[spmb_pkg::ST_MW_LSB +: N] = mfull_r;
        status[spmb_pkg::ST_SW_LSB +: N] = sfull_r;
    end

    // master read data; reading status has no side effect
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            m_rdata_r <= 8'h00;
        end else if (bus.m_rd) begin
            if (bus.m_addr == spmb_pkg::MA_STAT) begin
                m_rdata_r <= status;
            end else begin
                m_rdata_r <= sreg_r[bus.m_addr];
            end
        end
    end

    // slave read data; unmapped addresses read zero
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_rdata_r <= 8'h00;
        end else if (s_rd_i) begin
            if (s_addr_i < 3'(N)) begin
                s_rdata_r <= mreg_r[s_addr_i[1:0]];
            end else if (s_addr_i == spmb_pkg::SA_STAT) begin
                s_rdata_r <= status;
            end else if (s_addr_i == spmb_pkg::SA_CTRL) begin
                s_rdata_r <= {smode_r, 4'h0, prio_r};
            end else begin
                s_rdata_r <= 8'h00;
            end
        end
    end

    // attention: slave command write pulls it low, master status write
    // releases it; the slave write wins a tie so no event is lost
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            attn_n_r <= 1'b1;
        end else if (srst) begin
            attn_n_r <= 1'b1;
        end else if (sw[0]) begin
            attn_n_r <= 1'b0;
        end else if (bus.m_wr && bus.m_addr == spmb_pkg::MA_STAT) begin
            attn_n_r <= 1'b1;
        end
    end
    // slave reads of the command register never touch attn_n_r

    // pending interrupt: set by any master command write, even a dummy,
    // cleared by the slave handshake read; set wins
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_r <= 1'b0;
        end else if (srst) begin
            pend_r <= 1'b0;
        end else if (mw[0]) begin
            pend_r <= 1'b1;
        end else if (sr[0]) begin
            pend_r <= 1'b0;
        end
    end

    // priority field, may be lowered mid-message to go on by polling
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prio_r <= spmb_pkg::PRIO_OFF;
        end else if (srst) begin
            prio_r <= spmb_pkg::PRIO_OFF;
        end else if (s_wr_i && s_addr_i == spmb_pkg::SA_CTRL) begin
            prio_r <= s_wdata_i[1:0];
        end
    end

    // mode pins sampled on every clock, held or not; async reset loads the run code
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            smode_r <= spmb_pkg::SMODE_RUN;
        end else begin
            smode_r <= bus.smode;
        end
    end

    // a zero priority masks the request altogether
    assign irq_o = pend_r && (prio_r != spmb_pkg::PRIO_OFF);
    assign irq_level_o = prio_r;
    assign s_rdata_o = s_rdata_r;
    assign smode_o = smode_r;
    assign bus.m_rdata = m_rdata_r;
    assign bus.master_attention_n = attn_n_r;
endmodule : spmb_dev

// ==== rtl/spmb_mst.sv ====
module spmb_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // fill side
    input wire logic [W-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    // drain side
    output logic [W-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0] mem_r [DEPTH];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_r != (PW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_r[rp_r];

    // storage; no reset needed, guarded by the count
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_r[wp_r] <= in_data_i;
        end
    end

    // pointers wrap at DEPTH, which must be a power of two
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= push ? wp_r + 1'b1 : wp_r;
            rp_r <= pop ? rp_r + 1'b1 : rp_r;
            cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : spmb_fifo

module spmb_mst #(
    parameter int HOLD_CYC = spmb_pkg::BOOT_HOLD_CYC
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // link to the device
    spmb_if.mst bus,
    // outgoing message bytes
    input wire logic [spmb_pkg::DW-1:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    // received slave command and data
    output logic [spmb_pkg::DW-1:0] rx_cmd_o,
    output logic [spmb_pkg::DW-1:0] rx_aux_o,
    output logic rx_valid_o,
    // slave released from reset
    output logic boot_done_o
);
    spmb_pkg::spmb_state_t st_r;
    logic [spmb_pkg::DW-1:0] q_data;
    logic q_valid;
    logic q_pop;
    logic [15:0] hold_r;
    logic [spmb_pkg::DW-1:0] cmd_r;
    logic [spmb_pkg::DW-1:0] aux_r;
    logic rxv_r;

    // buffering decouples the user from the byte-wise handshake
    spmb_fifo #(.W(spmb_pkg::DW), .DEPTH(spmb_pkg::FIFO_DEPTH)) u_fifo (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .in_data_i(tx_data_i),
        .in_valid_i(tx_valid_i),
        .in_ready_o(tx_ready_o),
        .out_data_o(q_data),
        .out_valid_o(q_valid),
        .out_ready_i(q_pop)
    );

    // boot hold: slave kept in reset with the boot mode code
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hold_r <= '0;
        end else if (st_r == spmb_pkg::SPMB_BOOT) begin
            hold_r <= hold_r + 16'h0001;
        end
    end

    // sequencer; attention is served before the next outgoing byte
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= spmb_pkg::SPMB_BOOT;
        end else begin
            unique case (st_r)
                spmb_pkg::SPMB_BOOT:
                    if (hold_r >= 16'(HOLD_CYC - 1)) st_r <= spmb_pkg::SPMB_IDLE;
                spmb_pkg::SPMB_IDLE:
                    if (!bus.master_attention_n) st_r <= spmb_pkg::SPMB_A_ST;
                    else if (q_valid) st_r <= spmb_pkg::SPMB_P_RD;
                spmb_pkg::SPMB_P_RD: st_r <= spmb_pkg::SPMB_P_WT;
                spmb_pkg::SPMB_P_WT:
                    // wait for the command register to drain
                    if (!bus.m_rdata[spmb_pkg::ST_MW_LSB]) st_r <= spmb_pkg::SPMB_SEND;
                    else st_r <= spmb_pkg::SPMB_IDLE;
                spmb_pkg::SPMB_SEND: st_r <= spmb_pkg::SPMB_IDLE;
                spmb_pkg::SPMB_A_ST: st_r <= spmb_pkg::SPMB_A_SW;
                spmb_pkg::SPMB_A_SW:
                    if (bus.m_rdata[spmb_pkg::ST_SW_LSB]) st_r <= spmb_pkg::SPMB_A_AX;
                    else st_r <= spmb_pkg::SPMB_A_CL;
                spmb_pkg::SPMB_A_AX: st_r <= spmb_pkg::SPMB_A_AW;
                spmb_pkg::SPMB_A_AW: st_r <= spmb_pkg::SPMB_A_CM;
                spmb_pkg::SPMB_A_CM: st_r <= spmb_pkg::SPMB_A_CW;
                spmb_pkg::SPMB_A_CW: st_r <= spmb_pkg::SPMB_A_CL;
                spmb_pkg::SPMB_A_CL: st_r <= spmb_pkg::SPMB_IDLE;
                default: st_r <= spmb_pkg::SPMB_IDLE;
            endcase
        end
    end

    // capture of the slave's data byte and command byte
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aux_r <= 8'h00;
            cmd_r <= 8'h00;
            rxv_r <= 1'b0;
        end else begin
            rxv_r <= (st_r == spmb_pkg::SPMB_A_CW);
            if (st_r == spmb_pkg::SPMB_A_AW) aux_r <= bus.m_rdata;
            if (st_r == spmb_pkg::SPMB_A_CW) cmd_r <= bus.m_rdata;
        end
    end

    // bus strobes decoded from state; status peek does not consume
    always_comb begin
        bus.m_rd = 1'b0;
        bus.m_wr = 1'b0;
        bus.m_addr = spmb_pkg::MA_STAT;
        bus.m_wdata = 8'h00;
        q_pop = 1'b0;
        unique case (st_r)
            spmb_pkg::SPMB_P_RD, spmb_pkg::SPMB_A_ST: bus.m_rd = 1'b1;
            spmb_pkg::SPMB_SEND: begin
                bus.m_wr = 1'b1;
                bus.m_addr = spmb_pkg::MA_CMD;
                bus.m_wdata = q_data;
                q_pop = 1'b1;
            end
            spmb_pkg::SPMB_A_AX: begin
                bus.m_rd = 1'b1;
                bus.m_addr = spmb_pkg::MA_AUX;
            end
            spmb_pkg::SPMB_A_CM: begin
                bus.m_rd = 1'b1;
                bus.m_addr = spmb_pkg::MA_CMD;
            end
            spmb_pkg::SPMB_A_CL: bus.m_wr = 1'b1;
            default: ;
        endcase
    end

    assign bus.slave_rst_n = (st_r != spmb_pkg::SPMB_BOOT);
    assign bus.smode = (st_r == spmb_pkg::SPMB_BOOT) ? spmb_pkg::SMODE_BOOT
                                                     : spmb_pkg::SMODE_RUN;
    assign boot_done_o = (st_r != spmb_pkg::SPMB_BOOT);
    assign rx_cmd_o = cmd_r;
    assign rx_aux_o = aux_r;
    assign rx_valid_o = rxv_r;
endmodule : spmb_mst

// ==== testbench/spmb_properties.sv ====
module spmb_properties #(
    parameter int HOLD_CYC = spmb_pkg::BOOT_HOLD_CYC
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // link signals
    input wire logic [1:0] m_addr,
    input wire logic m_wr,
    input wire logic m_rd,
    input wire logic [spmb_pkg::DW-1:0] m_rdata,
    input wire logic master_attention_n,
    input wire logic slave_rst_n,
    input wire logic [1:0] smode
);
    timeunit 1ns;
    timeprecision 1ns;
    int hold_cnt_r;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);

    // cycles the slave spent held; a short hold would cut the boot
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hold_cnt_r <= 0;
        end else if (!slave_rst_n) begin
            hold_cnt_r <= hold_cnt_r + 1;
        end
    end

    a_boot_mode_pins: assert property (!slave_rst_n |-> smode == spmb_pkg::SMODE_BOOT)
        else $error("mode pins not at boot code while slave held");
    a_boot_no_access: assert property (!slave_rst_n |-> !m_wr && !m_rd)
        else $error("master access while slave held");
    a_boot_release: assert property ($rose(slave_rst_n) |-> smode == spmb_pkg::SMODE_RUN
        && hold_cnt_r >= HOLD_CYC)
        else $error("slave released early or with wrong mode");
    // a byte goes out only after a status read showed the register empty
    a_send_after_empty: assert property (m_wr && m_addr == spmb_pkg::MA_CMD |->
        $past(m_rd, 2) && $past(m_addr, 2) == spmb_pkg::MA_STAT
        && ($past(m_rdata) & 8'h01) == 8'h00)
        else $error("command written without seeing it empty");
    a_peek_before_aux: assert property (m_rd && m_addr == spmb_pkg::MA_AUX |->
        $past(m_rd, 2) && $past(m_addr, 2) == spmb_pkg::MA_STAT
        && ($past(m_rdata) & 8'h10) != 8'h00)
        else $error("data read without status peek");
    a_cmd_after_aux: assert property (m_rd && m_addr == spmb_pkg::MA_CMD |->
        $past(m_rd, 2) && $past(m_addr, 2) == spmb_pkg::MA_AUX)
        else $error("command read not after data read");
    a_stat_wr_release: assert property (m_wr && m_addr == spmb_pkg::MA_STAT |=>
        master_attention_n)
        else $error("attention not released by status write");
    a_attn_answered: assert property ($fell(master_attention_n) |->
        ##[1:12] (m_rd && m_addr == spmb_pkg::MA_STAT))
        else $error("attention not answered by status peek");
    // read data holds until the next read strobe
    a_rdata_stands: assert property (!$past(m_rd) |-> $stable(m_rdata))
        else $error("master read data changed without a read");
endmodule : spmb_properties

// ==== testbench/slave_port_mailbox_handshake_tb.sv ====
module slave_port_mailbox_handshake_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // short boot hold keeps the run brief
    localparam int HOLD = 4;
    logic mclk_i, nrst_i, s_wr_i, s_rd_i, irq_o, tx_valid_i, tx_ready_o, rx_valid_o, boot_done_o;
    logic [2:0] s_addr_i;
    logic [7:0] s_wdata_i, s_rdata_o, tx_data_i, rx_cmd_o, rx_aux_o;
    logic [1:0] irq_level_o, smode_o;
    logic [2:0] flags;
    int n_fail = 0;
    int n_checks = 0;

    spmb_if bus_if();
    spmb_dev u_spmb_dev (.mclk_i(mclk_i), .nrst_i(nrst_i), .bus(bus_if), .s_addr_i(s_addr_i),
        .s_wr_i(s_wr_i), .s_rd_i(s_rd_i), .s_wdata_i(s_wdata_i), .s_rdata_o(s_rdata_o),
        .irq_o(irq_o), .irq_level_o(irq_level_o), .smode_o(smode_o));
    spmb_mst #(.HOLD_CYC(HOLD)) u_spmb_mst (.mclk_i(mclk_i), .nrst_i(nrst_i), .bus(bus_if),
        .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
        .rx_cmd_o(rx_cmd_o), .rx_aux_o(rx_aux_o), .rx_valid_o(rx_valid_o),
        .boot_done_o(boot_done_o));
    spmb_properties #(.HOLD_CYC(HOLD)) u_spmb_properties (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .m_addr(bus_if.m_addr), .m_wr(bus_if.m_wr), .m_rd(bus_if.m_rd),
        .m_rdata(bus_if.m_rdata), .master_attention_n(bus_if.master_attention_n),
        .slave_rst_n(bus_if.slave_rst_n), .smode(bus_if.smode));

    // flags a bounded wait can watch
    assign flags = {rx_valid_o, irq_o, boot_done_o};

    // 100 MHz clock
    initial begin
        mclk_i = 1'h0;
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic time_out(input string nm);
        n_fail++;
        $display("wrong value %s expected 1 seen 0", nm);
        report_and_stop();
    endtask : time_out

    // flags are sampled just after the edge so that edge's updates have landed
    task automatic wait_hi(input int b, input string nm);
        for (int i = 0; i < 300; i++) begin
            @(posedge mclk_i);
            #1;
            if (flags[b] === 1'h1) return;
        end
        time_out(nm);
    endtask : wait_hi

    task automatic s_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        s_addr_i <= a;
        s_wdata_i <= d;
        s_wr_i <= 1'h1;
        @(posedge mclk_i);
        s_wr_i <= 1'h0;
        #1;
    endtask : s_write

    task automatic s_read(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        s_addr_i <= a;
        s_rd_i <= 1'h1;
        @(posedge mclk_i);
        s_rd_i <= 1'h0;
        #1;
        d = s_rdata_o;
    endtask : s_read

    // polls status until the master's command byte is waiting, then takes it
    task automatic s_pop(input logic [7:0] exp);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < 50 && v[0] !== 1'h1; i++) begin
            s_read(spmb_pkg::SA_STAT, v);
        end
        if (v[0] !== 1'h1) time_out("status poll");
        check("no irq while polled", 8'h00, {7'h00, irq_o & ~|irq_level_o});
        s_read(3'h0, v);
        check("cmd byte", exp, v);
    endtask : s_pop

    // holds valid until ready is seen; gives up after a bounded wait
    task automatic push(input logic [7:0] d, output logic ok);
        logic rdy;
        ok = 1'h0;
        @(posedge mclk_i);
        tx_data_i <= d;
        tx_valid_i <= 1'h1;
        for (int i = 0; i < 30 && !ok; i++) begin
            @(negedge mclk_i);
            rdy = tx_ready_o;
            @(posedge mclk_i);
            ok = rdy;
        end
        tx_valid_i <= 1'h0;
        // let the accepting edge settle before callers look at outputs
        #1;
    endtask : push

    initial begin
        logic [7:0] v;
        logic ok;
        int n;
        {nrst_i, s_wr_i, s_rd_i, tx_valid_i} = 4'h0;
        s_addr_i = 3'h0;
        s_wdata_i = 8'h00;
        tx_data_i = 8'h00;
        repeat (3) @(posedge mclk_i);
        nrst_i <= 1'h1;
        @(posedge mclk_i);
        #1;
        check("mode pins", {6'h00, spmb_pkg::SMODE_BOOT}, {6'h00, smode_o});
        wait_hi(0, "boot done");
        repeat (2) @(posedge mclk_i);
        #1;
        check("mode pins", {6'h00, spmb_pkg::SMODE_RUN}, {6'h00, smode_o});
        s_read(spmb_pkg::SA_STAT, v);
        check("status", 8'h00, v);
        s_write(3'h5, 8'hFF);
        s_read(3'h5, v);
        check("unmapped", 8'h00, v);
        // priority zero: byte arrives with no interrupt
        s_write(spmb_pkg::SA_CTRL, 8'h00);
        push(8'hA5, ok);
        check("push accepted", 8'h01, {7'h00, ok});
        s_pop(8'hA5);
        s_read(spmb_pkg::SA_STAT, v);
        check("status", 8'h00, v);
        s_read(spmb_pkg::SA_CTRL, v);
        check("ctrl", 8'h00, v);
        // each enabled level raises the interrupt; lowering it to zero quiets it
        for (int p = 1; p < 4; p++) begin
            s_write(spmb_pkg::SA_CTRL, 8'(p));
            push(8'(8'h10 + p), ok);
            check("push accepted", 8'h01, {7'h00, ok});
            wait_hi(1, "irq");
            check("irq level", 8'(p), {6'h00, irq_level_o});
            if (p == 3) begin
                s_write(spmb_pkg::SA_CTRL, 8'h00);
                check("irq lowered", 8'h00, {7'h00, irq_o});
            end
            s_pop(8'(8'h10 + p));
            check("irq after read", 8'h00, {7'h00, irq_o});
            check("attention", 8'h01, {7'h00, bus_if.master_attention_n});
        end
        // fill while the slave stalls: one byte in the register, sixteen buffered
        n = 0;
        ok = 1'h1;
        for (int i = 0; i < 20 && ok; i++) begin
            push(8'(i), ok);
            n += int'(ok);
        end
        check("accepted", 8'h11, 8'(n));
        check("ready", 8'h00, {7'h00, tx_ready_o});
        for (int i = 0; i < n; i++) begin
            s_pop(8'(i));
        end
        check("ready", 8'h01, {7'h00, tx_ready_o});
        // slave to master: data then command, master peeks and handshakes
        s_write(3'h1, 8'h3C);
        s_write(3'h0, 8'h81);
        check("attention", 8'h00, {7'h00, bus_if.master_attention_n});
        wait_hi(2, "rx valid");
        check("rx cmd", 8'h81, rx_cmd_o);
        check("rx data", 8'h3C, rx_aux_o);
        repeat (3) @(posedge mclk_i);
        #1;
        check("attention", 8'h01, {7'h00, bus_if.master_attention_n});
        s_read(spmb_pkg::SA_STAT, v);
        check("status", 8'h00, v);
        report_and_stop();
    end
endmodule : slave_port_mailbox_handshake_tb
